// ==== src/plosc_pkg.sv ====
package plosc_pkg;

	// ------------------------------------------------------------
	// clock and link timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 20;
	localparam int SCL_QUARTER_NS  = 2500;
	localparam int SCL_QUARTER_CYC =
		(SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] QCNT_LAST = 8'(SCL_QUARTER_CYC - 1);
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [3:0] BIT_END   = 4'h9;

	// ------------------------------------------------------------
	// device side
	// ------------------------------------------------------------
	localparam logic [4:0] SLAVE_ADDR_HI  = 5'h0B;
	localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
	localparam logic       AUX_RESET      = 1'h0;
	localparam logic [4:0] SYNC_RESET     = 5'h18;
	localparam int INSTR_SEL_BIT = 7;
	localparam int INSTR_RS_BIT  = 6;
	localparam int INSTR_SD_BIT  = 5;
	localparam int INSTR_O2_BIT  = 4;
	localparam int INSTR_O1_BIT  = 3;

	// ------------------------------------------------------------
	// controller registers
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_CMD    = 8'h00;
	localparam logic [7:0]  REG_TARGET = 8'h04;
	localparam logic [7:0]  REG_STATUS = 8'h08;
	localparam logic [31:0] CMD_RESET  = 32'h0;
	localparam logic [6:0]  TARGET_RESET = 7'h2C;
	localparam int CMD_DATA_LSB   = 8;
	localparam int CMD_WDATA_BIT  = 16;
	localparam int CMD_READ_BIT   = 17;
	localparam int CMD_NOSTOP_BIT = 18;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		DS_IDLE  = 5'h01,
		DS_ADDR  = 5'h02,
		DS_INSTR = 5'h04,
		DS_DATA  = 5'h08,
		DS_READ  = 5'h10
	} plosc_dev_state_t;

	typedef enum logic [3:0] {
		HS_IDLE  = 4'h1,
		HS_START = 4'h2,
		HS_BIT   = 4'h4,
		HS_STOP  = 4'h8
	} plosc_host_state_t;

endpackage

// ==== src/plosc_if.sv ====
`timescale 1ns/1ps
interface plosc_if;
	logic m_scl_oe;
	logic m_scl_o;
	logic m_sda_oe;
	logic m_sda_o;
	logic s_sda_oe;
	logic s_sda_o;
	logic scl;
	logic sda;

	// wired-and with pull-ups
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport master (
		output m_scl_oe,
		output m_scl_o,
		output m_sda_oe,
		output m_sda_o,
		input  scl,
		input  sda
	);

	modport slave (
		output s_sda_oe,
		output s_sda_o,
		input  scl,
		input  sda
	);
endinterface

// ==== src/plosc_dev.sv ====
`timescale 1ns/1ps
module plosc_dev
	import plosc_pkg::*;
(
	input  wire logic            aclk,
	input  wire logic            aresetn,
	plosc_if.slave               link,
	input  wire logic            shutdown_pin_n,
	input  wire logic            addr_pin_0,
	input  wire logic            addr_pin_1,
	output logic                 aux_logic_out_1,
	output logic                 aux_logic_out_2,
	output logic [1:0][7:0]      wiper_register,
	output logic [1:0]           term_a_open,
	output logic [1:0]           wiper_to_b
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [4:0]       in_meta;
	logic [4:0]       in_sync;
	logic [1:0]       line_prev;
	logic             scl;
	logic             sda;
	logic             shutdown_pin_n_n;
	logic [6:0]       my_addr;
	logic             scl_rise;
	logic             scl_fall;
	logic             bus_start;
	logic             bus_stop;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// shutdown bit resets low: no wake blip after reset
			in_meta <= SYNC_RESET;
			in_sync <= SYNC_RESET;
		end else begin
			in_meta <= {link.scl, link.sda, shutdown_pin_n,
			            addr_pin_1, addr_pin_0};
			in_sync <= in_meta;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_prev <= 2'h3;
		end else begin
			line_prev <= in_sync[4:3];
		end
	end

	assign scl       = in_sync[4];
	assign sda       = in_sync[3];
	assign shutdown_pin_n_n    = in_sync[2];
	assign my_addr   = {SLAVE_ADDR_HI, in_sync[1:0]};
	assign scl_rise  = scl & ~line_prev[1];
	assign scl_fall  = ~scl & line_prev[1];
	// sda edges only count while scl stays high
	assign bus_start = scl & line_prev[1] & line_prev[0] & ~sda;
	assign bus_stop  = scl & line_prev[1] & ~line_prev[0] & sda;

	// ------------------------------------------------------------
	// serial state machine
	// ------------------------------------------------------------
	plosc_dev_state_t state;
	logic [3:0]       bit_cnt;
	logic [7:0]       shreg;
	logic [7:0]       tx_byte;
	logic             rw_q;
	logic             sda_oe;
	logic             sda_o;
	logic             sel;
	logic             instr_take;
	logic             data_take;
	logic [7:0]       rd_value;

	assign rd_value = wiper_register[sel];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= DS_IDLE;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			tx_byte <= 8'h00;
			rw_q    <= 1'h0;
			sda_oe  <= 1'h0;
		end else if (bus_start) begin
			// a repeated start is handled as a fresh one
			state   <= DS_ADDR;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'h0;
		end else if (bus_stop) begin
			state   <= DS_IDLE;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'h0;
		end else if (state != DS_IDLE && scl_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
			if (bit_cnt < BIT_ACK) begin
				shreg <= {shreg[6:0], sda};
			end
			// master nack ends readback
			if (bit_cnt == BIT_ACK && state == DS_READ && sda) begin
				state <= DS_IDLE;
			end
		end else if (state != DS_IDLE && scl_fall) begin
			if (bit_cnt == BIT_ACK) begin
				case (state)
					DS_ADDR: begin
						rw_q <= shreg[0];
						if (shreg[7:1] == my_addr) begin
							sda_oe <= 1'h1;
						end else begin
							state <= DS_IDLE;
						end
					end
					DS_INSTR, DS_DATA: begin
						sda_oe <= 1'h1;
					end
					DS_READ: begin
						sda_oe <= 1'h0;
					end
					default: begin
						sda_oe <= 1'h0;
					end
				endcase
			end else if (bit_cnt == BIT_END) begin
				bit_cnt <= 4'h0;
				sda_oe  <= 1'h0;
				case (state)
					DS_ADDR: begin
						if (rw_q) begin
							state   <= DS_READ;
							tx_byte <= rd_value;
							sda_oe  <= ~rd_value[7];
						end else begin
							state <= DS_INSTR;
						end
					end
					DS_INSTR: begin
						state <= DS_DATA;
					end
					DS_READ: begin
						tx_byte <= rd_value;
						sda_oe  <= ~rd_value[7];
					end
					default: begin
						sda_oe <= 1'h0;
					end
				endcase
			end else if (state == DS_READ) begin
				sda_oe <= ~tx_byte[3'(4'h7 - bit_cnt)];
			end
		end
	end

	// open-drain: only ever pulls low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sda_o <= 1'h0;
		end else begin
			sda_o <= 1'h0;
		end
	end

	assign link.s_sda_oe = sda_oe;
	assign link.s_sda_o  = sda_o;

	// scl_fall and a start or stop never meet: both need scl high
	assign instr_take = scl_fall && bit_cnt == BIT_ACK
	                    && state == DS_INSTR;
	assign data_take  = scl_fall && bit_cnt == BIT_ACK
	                    && state == DS_DATA;

	// ------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------
	logic [1:0]       soft_sd;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_logic_out_1 <= AUX_RESET;
			aux_logic_out_2 <= AUX_RESET;
			sel             <= 1'h0;
			soft_sd         <= 2'h0;
		end else if (instr_take) begin
			aux_logic_out_1 <= shreg[INSTR_O1_BIT];
			aux_logic_out_2 <= shreg[INSTR_O2_BIT];
			sel             <= shreg[INSTR_SEL_BIT];
			// any new command lifts an earlier soft shutdown
			soft_sd <= 2'h0;
			soft_sd[shreg[INSTR_SEL_BIT]] <= shreg[INSTR_SD_BIT];
		end
	end

	// ------------------------------------------------------------
	// wiper storage
	// ------------------------------------------------------------
	// writes go through in shutdown so an o1-to-pin loop can wake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wiper_register[0] <= WIPER_MIDSCALE;
			wiper_register[1] <= WIPER_MIDSCALE;
		end else if (instr_take && shreg[INSTR_RS_BIT]) begin
			wiper_register[shreg[INSTR_SEL_BIT]] <= WIPER_MIDSCALE;
		end else if (data_take) begin
			wiper_register[sel] <= shreg;
		end
	end

	// ------------------------------------------------------------
	// per-channel shutdown switches
	// ------------------------------------------------------------
	// held shut during reset: the safe state for the load
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					term_a_open[ch] <= 1'h1;
					wiper_to_b[ch]  <= 1'h1;
				end else begin
					term_a_open[ch] <= ~shutdown_pin_n_n | soft_sd[ch];
					wiper_to_b[ch]  <= ~shutdown_pin_n_n | soft_sd[ch];
				end
			end
		end
	endgenerate

endmodule

// ==== src/plosc_host.sv ====
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module plosc_host
	import plosc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	plosc_if.master          link
);

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic [7:0]        aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              aw_got;
	logic              w_got;
	logic              wr_fire;
	logic              next_aw_got;
	logic              next_w_got;
	logic              next_bvalid;
	logic              next_rvalid;
	logic [31:0]       cmd;
	logic [31:0]       next_cmd;
	logic [6:0]        target;
	logic              launch;
	logic              nack;
	logic [7:0]        rx_data;
	plosc_host_state_t state;

	assign wr_fire     = aw_got && w_got && !bvalid;
	assign next_aw_got = aw_got ? !wr_fire : (awvalid && awready);
	assign next_w_got  = w_got ? !wr_fire : (wvalid && wready);
	assign next_bvalid = bvalid ? !bready : wr_fire;
	assign next_rvalid = rvalid ? !rready : (arvalid && arready);
	assign launch = wr_fire && aw_addr == REG_CMD && state == HS_IDLE;

	always_comb begin
		next_cmd = cmd;
		for (int b = 0; b < 4; b++) begin
			if (w_strb[b]) begin
				next_cmd[b*8 +: 8] = w_data[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got  <= 1'h0;
			w_got   <= 1'h0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			awready <= 1'h0;
			wready  <= 1'h0;
			bvalid  <= 1'h0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
			aw_got  <= next_aw_got;
			w_got   <= next_w_got;
			awready <= !next_aw_got && !next_bvalid;
			wready  <= !next_w_got && !next_bvalid;
			bvalid  <= next_bvalid;
			if (wr_fire) begin
				// busy command write or unknown offset is refused
				bresp <= (launch || aw_addr == REG_TARGET)
				         ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd    <= CMD_RESET;
			target <= TARGET_RESET;
		end else if (launch) begin
			cmd <= next_cmd;
		end else if (wr_fire && aw_addr == REG_TARGET) begin
			target <= next_cmd[6:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'h0;
			rvalid  <= 1'h0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end else begin
			rvalid  <= next_rvalid;
			arready <= !next_rvalid;
			if (arvalid && arready) begin
				rresp <= RESP_OKAY;
				case (araddr)
					REG_CMD:    rdata <= cmd;
					REG_TARGET: rdata <= {25'h0, target};
					REG_STATUS: rdata <= {16'h0, rx_data, 6'h0, nack,
					                      state != HS_IDLE};
					default: begin
						rdata <= 32'h0;
						rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// link engine, four quarters per scl period
	// ------------------------------------------------------------
	logic [1:0]  in_meta;
	logic [1:0]  in_sync;
	logic [7:0]  qcnt;
	logic [1:0]  phase;
	logic [3:0]  bit_cnt;
	logic [1:0]  idx;
	logic [7:0]  txb;
	logic [7:0]  rxb;
	logic        scl_oe;
	logic        sda_oe;
	logic        drv_o;
	logic        tick;
	logic        is_read;
	logic        last_byte;
	logic [7:0]  byte_next;

	assign tick      = qcnt == QCNT_LAST;
	assign is_read   = cmd[CMD_READ_BIT];
	assign last_byte = idx == 2'h2
	                   || (idx == 2'h1 && (is_read || !cmd[CMD_WDATA_BIT]));
	// a read byte is all released bits; its ninth bit is the nack
	assign byte_next = idx == 2'h0
	                   ? (is_read ? 8'hFF : cmd[7:0])
	                   : cmd[CMD_DATA_LSB +: 8];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_meta <= 2'h3;
			in_sync <= 2'h3;
			drv_o   <= 1'h0;
		end else begin
			in_meta <= {link.scl, link.sda};
			in_sync <= in_meta;
			drv_o   <= 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= HS_IDLE;
			qcnt    <= 8'h00;
			phase   <= 2'h0;
			bit_cnt <= 4'h0;
			idx     <= 2'h0;
			txb     <= 8'h00;
			rxb     <= 8'h00;
			rx_data <= 8'h00;
			nack    <= 1'h0;
			scl_oe  <= 1'h0;
			sda_oe  <= 1'h0;
		end else if (launch) begin
			// start from idle or from an open cycle alike
			state <= HS_START;
			qcnt  <= 8'h00;
			phase <= 2'h0;
			nack  <= 1'h0;
		end else if (state != HS_IDLE) begin
			qcnt <= tick ? 8'h00 : qcnt + 8'h01;
			if (tick) begin
				phase <= phase + 2'h1;
				case (state)
					HS_START: begin
						case (phase)
							2'h0: sda_oe <= 1'h0;
							2'h1: scl_oe <= 1'h0;
							2'h2: sda_oe <= 1'h1;
							default: begin
								scl_oe  <= 1'h1;
								state   <= HS_BIT;
								bit_cnt <= 4'h0;
								idx     <= 2'h0;
								txb     <= {target, is_read};
							end
						endcase
					end
					HS_BIT: begin
						case (phase)
							2'h0: sda_oe <= bit_cnt < BIT_ACK && !txb[7];
							2'h1: scl_oe <= 1'h0;
							2'h2: begin
								if (bit_cnt < BIT_ACK) begin
									rxb <= {rxb[6:0], in_sync[0]};
								end else if (!(is_read && idx == 2'h1)) begin
									nack <= in_sync[0];
								end
							end
							default: begin
								scl_oe <= 1'h1;
								if (bit_cnt < BIT_ACK) begin
									txb     <= {txb[6:0], 1'h0};
									bit_cnt <= bit_cnt + 4'h1;
								end else if (nack || last_byte) begin
									if (is_read) begin
										rx_data <= rxb;
									end
									// open cycle: scl held low, no stop
									state <= (cmd[CMD_NOSTOP_BIT] && !nack)
									         ? HS_IDLE : HS_STOP;
								end else begin
									bit_cnt <= 4'h0;
									idx     <= idx + 2'h1;
									txb     <= byte_next;
								end
							end
						endcase
					end
					HS_STOP: begin
						case (phase)
							2'h0: sda_oe <= 1'h1;
							2'h1: scl_oe <= 1'h0;
							2'h2: sda_oe <= 1'h0;
							default: state <= HS_IDLE;
						endcase
					end
					default: state <= HS_IDLE;
				endcase
			end
		end
	end

	assign link.m_scl_oe = scl_oe;
	assign link.m_scl_o  = drv_o;
	assign link.m_sda_oe = sda_oe;
	assign link.m_sda_o  = drv_o;

endmodule

// ==== tb/plosc_assertions.sv ====
`timescale 1ns/1ps
module plosc_assertions
	import plosc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic m_scl_oe,
	input wire logic m_scl_o,
	input wire logic m_sda_oe,
	input wire logic m_sda_o,
	input wire logic s_sda_oe,
	input wire logic s_sda_o,
	input wire logic scl,
	input wire logic sda
);
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	localparam int HIGH_MIN = 2 * SCL_QUARTER_CYC;
	localparam int LOW_MIN  = SCL_QUARTER_CYC;
	// a read byte of all zeros is the longest the device may hold sda
	localparam int DEV_MAX  = 36 * SCL_QUARTER_CYC;
	int unsigned high_cnt;
	int unsigned low_cnt;
	int unsigned dev_cnt;

	always_ff @(posedge aclk) begin
		if (!aresetn || !scl)
			high_cnt <= 0;
		else
			high_cnt <= high_cnt + 1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || scl)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !s_sda_oe)
			dev_cnt <= 0;
		else
			dev_cnt <= dev_cnt + 1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// link properties
	// ------------------------------------------------------------
	chk_mscl_open_drain: assert property (!m_scl_o)
		else $error("master scl data not low");
	chk_msda_open_drain: assert property (!m_sda_o)
		else $error("master sda data not low");
	chk_dsda_open_drain: assert property (!s_sda_o)
		else $error("device sda data not low");
	chk_reset_released: assert property ($rose(aresetn) |->
		!m_scl_oe && !m_sda_oe && !s_sda_oe)
		else $error("link driven right after reset");
	chk_dev_sda_steady: assert property (scl && $past(scl) |->
		$stable(s_sda_oe))
		else $error("device moved sda while scl high");
	chk_cond_by_master: assert property (scl && $past(scl) &&
		(sda != $past(sda)) |-> (m_sda_oe != $past(m_sda_oe)))
		else $error("start or stop not made by master");
	chk_scl_high_min: assert property ($fell(scl) |->
		high_cnt >= HIGH_MIN)
		else $error("scl high phase too short");
	chk_scl_low_min: assert property ($rose(scl) |->
		low_cnt >= LOW_MIN)
		else $error("scl low phase too short");
	chk_dev_hold_max: assert property (dev_cnt <= DEV_MAX)
		else $error("device holds sda too long");

	cov_start: cover property (scl && $fell(sda));
	cov_stop: cover property (scl && $rose(sda));
	cov_dev_ack: cover property ($rose(s_sda_oe));
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb
	import plosc_pkg::*;
;
	logic            aclk;
	logic            aresetn;
	logic [7:0]      awaddr;
	logic            awvalid;
	logic            awready;
	logic [31:0]     wdata;
	logic            wvalid;
	logic            wready;
	logic [1:0]      bresp;
	logic            bvalid;
	logic            bready;
	logic [7:0]      araddr;
	logic            arvalid;
	logic            arready;
	logic [31:0]     rdata;
	logic [1:0]      rresp;
	logic            rvalid;
	logic            rready;
	logic            pin_drv;
	logic            loop_mode;
	logic            shutdown_pin_n;
	logic            aux1;
	logic            aux2;
	logic [1:0][7:0] wiper;
	logic [1:0]      term_a_open;
	logic [1:0]      wiper_to_b;
	logic [1:0]      r;
	logic [31:0]     s;
	int              fail_count;
	int              total_checks;

	// self-contained shutdown: aux output 1 wired back to the pin
	assign shutdown_pin_n = loop_mode ? aux1 : pin_drv;

	plosc_if u_plosc_if ();

	plosc_dev u_plosc_dev (.aclk(aclk), .aresetn(aresetn),
		.link(u_plosc_if), .shutdown_pin_n(shutdown_pin_n),
		.addr_pin_0(1'b0), .addr_pin_1(1'b0), .aux_logic_out_1(aux1),
		.aux_logic_out_2(aux2), .wiper_register(wiper),
		.term_a_open(term_a_open), .wiper_to_b(wiper_to_b));

	plosc_host u_plosc_host (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link(u_plosc_if));

	plosc_assertions u_plosc_assertions (.aclk(aclk), .aresetn(aresetn),
		.m_scl_oe(u_plosc_if.m_scl_oe), .m_scl_o(u_plosc_if.m_scl_o),
		.m_sda_oe(u_plosc_if.m_sda_oe), .m_sda_o(u_plosc_if.m_sda_o),
		.s_sda_oe(u_plosc_if.s_sda_oe), .s_sda_o(u_plosc_if.s_sda_o),
		.scl(u_plosc_if.scl), .sda(u_plosc_if.sda));

	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %h not %h", $time, seen, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				s = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// poll busy; the watchdog ends a hung transfer
	task automatic wait_idle();
		s = 32'h1;
		while (s[0] !== 1'b0)
			axi_rd(REG_STATUS);
		check(32'(s[1]), 32'h0);
		repeat (10) @(posedge aclk);
	endtask

	task automatic run_cmd(input logic [31:0] cmd);
		axi_wr(REG_CMD, cmd);
		check(32'(r), 32'(RESP_OKAY));
		wait_idle();
	endtask

	task automatic outs(input logic [1:0] aux_e, input logic [15:0] wip_e,
			input logic [1:0] sd_e);
		check(32'({aux2, aux1}), 32'(aux_e));
		check(32'(wiper), 32'(wip_e));
		check(32'(term_a_open), 32'(sd_e));
		check(32'(wiper_to_b), 32'(sd_e));
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		repeat (20) @(posedge aclk);
		outs(2'h0, 16'h8080, 2'h3);
		aresetn <= 1'b1;
		repeat (10) @(posedge aclk);
		outs(2'h0, 16'h8080, 2'h0);
		$display("reset done");
	endtask

	task automatic t_instr_only();
		axi_wr(REG_CMD, 32'h0000000D);
		check(32'(r), 32'(RESP_OKAY));
		axi_wr(REG_CMD, 32'h00011108);
		check(32'(r), 32'(RESP_SLVERR));
		wait_idle();
		outs(2'h1, 16'h8080, 2'h0);
		$display("instruction only done");
	endtask

	task automatic t_after_stop();
		run_cmd(32'h00013C8A);
		outs(2'h1, 16'h3C80, 2'h0);
		run_cmd(32'h00020000);
		check(32'(s[15:8]), 32'h3C);
		run_cmd(32'h00000013);
		outs(2'h2, 16'h3C80, 2'h0);
		$display("after stop done");
	endtask

	task automatic t_soft_shutdown();
		run_cmd(32'h000400AC);
		outs(2'h1, 16'h3C80, 2'h2);
		run_cmd(32'h00000099);
		outs(2'h3, 16'h3C80, 2'h0);
		$display("soft shutdown done");
	endtask

	task automatic t_pin_shutdown();
		pin_drv <= 1'b0;
		repeat (10) @(posedge aclk);
		outs(2'h3, 16'h3C80, 2'h3);
		pin_drv <= 1'b1;
		repeat (10) @(posedge aclk);
		outs(2'h3, 16'h3C80, 2'h0);
		$display("pin shutdown done");
	endtask

	task automatic t_regs();
		axi_rd(8'h0C);
		check(s, 32'h0);
		check(32'(r), 32'(RESP_SLVERR));
		axi_wr(8'h0C, 32'h0);
		check(32'(r), 32'(RESP_SLVERR));
		axi_wr(REG_STATUS, 32'h0);
		check(32'(r), 32'(RESP_SLVERR));
		axi_rd(REG_TARGET);
		check(s, 32'(TARGET_RESET));
		$display("registers done");
	endtask

	task automatic t_self_shutdown();
		loop_mode <= 1'b1;
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// no wake blip while the looped pin still crosses the sync
		repeat (3) begin
			@(posedge aclk);
			check(32'(term_a_open), 32'h3);
		end
		repeat (7) @(posedge aclk);
		outs(2'h0, 16'h8080, 2'h3);
		run_cmd(32'h00011106);
		outs(2'h0, 16'h8011, 2'h3);
		run_cmd(32'h00000048);
		outs(2'h1, 16'h8080, 2'h0);
		$display("self shutdown done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// about 90k cycles of traffic expected; a fifth more as margin
	initial begin
		#2_200_000;
		fail_count++;
		results();
	end

	initial begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		pin_drv = 1'b1;
		loop_mode = 1'b0;
		fail_count = 0;
		total_checks = 0;
		t_reset();
		t_instr_only();
		t_after_stop();
		t_soft_shutdown();
		t_pin_shutdown();
		t_regs();
		t_self_shutdown();
		results();
	end
endmodule
